// ===== logic/programmable_io_port_bank.sv
`timescale 1ns/1ps
`default_nettype none
module programmable_io_port_bank (
	input wire logic clk_sys,
	input wire logic arst_n,
	input wire logic ce,
	input wire logic wr_en,
	input wire io_bank_pkg::wr_sel_e wr_sel,
	input wire logic [3:0] wr_addr,
	input wire io_bank_pkg::byte_t wr_data,
	input wire logic rd_en,
	input wire logic [3:0] rd_addr,
	output logic [7:0] rd_data,
	output logic rd_valid,
	input wire logic ext_mode,
	input wire logic bus_8bit,
	input wire logic mux_full_space,
	input wire io_bank_pkg::slot_t periph_oe,
	input wire io_bank_pkg::slot_t periph_out,
	input wire io_bank_pkg::slot_t pin_in,
	input wire logic input_only_pin,
	output io_bank_pkg::slot_t pin_out,
	output io_bank_pkg::slot_t pin_oe,
	output io_bank_pkg::slot_t pin_pullup,
	output logic readback_latch
);
	import io_bank_pkg::*;

	typedef struct packed {
		slot_t dir;
		slot_t latch;
		group_t pug;
		logic portctl;
		byte_t rd_data;
		logic rd_valid;
		slot_t pin_out;
		slot_t pin_oe;
		slot_t pin_pullup;
		logic readback_latch;
	} bank_state_s;

	localparam bank_state_s STATE_RESET = '{
		dir: DIR_RESET,
		latch: LATCH_RESET,
		pug: PU_RESET,
		portctl: PORTCTL_RESET,
		rd_data: '0,
		rd_valid: 1'b0,
		pin_out: '0,
		pin_oe: '0,
		pin_pullup: '0,
		readback_latch: 1'b0
	};

	bank_state_s st;
	bank_state_s next_st;
	pin_ctl_if pc ();
	logic p1_sel_active;
	slot_t pin_level;

	// Lowest slot of a port
	function automatic int port_base(input logic [3:0] port);
		return int'(port) * PORT_W;
	endfunction

	// Replace one byte of a slot vector, keeping the no-direction slot clear
	function automatic slot_t put_byte(input slot_t cur, input logic [3:0] port,
		input byte_t val, input slot_t keep);
		slot_t res;
		res = cur;
		for (int b = 0; b < PORT_W; b++) begin
			res[port_base(port) + b] = val[b];
		end
		return (res & keep) | (cur & ~keep);
	endfunction

	// Pick one byte out of a slot vector
	function automatic byte_t get_byte(input slot_t v, input logic [3:0] port);
		byte_t res;
		res = '0;
		for (int b = 0; b < PORT_W; b++) begin
			res[b] = v[port_base(port) + b];
		end
		return res;
	endfunction

	// Control state handed to the drive calculation
	assign pc.dir = st.dir;
	assign pc.latch = st.latch;
	assign pc.pug = st.pug;
	assign pc.ext_mode = ext_mode;
	assign pc.periph_oe = periph_oe;
	assign pc.periph_out = periph_out;

	pin_drive_calc u_drive (
		.pc(pc)
	);

	// The input-only pin is read in its own slot; it never has a driver
	always_comb begin
		pin_level = pin_in;
		pin_level[IN_ONLY_SLOT] = input_only_pin;
	end

	// Port one read-back switch only counts in the narrow or multiplexed bus setups
	assign p1_sel_active = (ext_mode && bus_8bit) || mux_full_space;

	// Next-state: register writes, reads, and registered pin drive
	always_comb begin
		byte_t rd_val;
		byte_t p1_dir;
		next_st = st;
		rd_val = '0;
		p1_dir = get_byte(st.dir, PORT_ONE);
		if (wr_en && wr_addr <= PORT_LAST) begin
			case (wr_sel)
				SEL_DIR: begin
					// Bit b of the byte is pin b of the addressed port
					next_st.dir = put_byte(st.dir, wr_addr, wr_data, VALID_MASK);
				end
				SEL_LATCH: begin
					next_st.latch = put_byte(st.latch, wr_addr, wr_data, VALID_MASK);
				end
				SEL_PULLUP: begin
					// Pull-up byte n holds groups 8n to 8n+7
					if (wr_addr[3:2] == 2'h0 && wr_addr[1:0] <= PU_BYTE_LAST) begin
						for (int g = 0; g < PORT_W; g++) begin
							if (int'(wr_addr[1:0]) * PORT_W + g < NUM_GROUPS) begin
								next_st.pug[int'(wr_addr[1:0]) * PORT_W + g] = wr_data[g];
							end
						end
					end
				end
				SEL_PORTCTL: begin
					if (wr_addr == 4'h0) begin
						next_st.portctl = wr_data[READBACK_BIT];
					end
				end
				default: begin
					next_st.portctl = st.portctl;
				end
			endcase
		end
		if (rd_en) begin
			case (wr_sel)
				default: begin
					rd_val = '0;
				end
			endcase
			if (rd_addr <= PORT_LAST) begin
				// Ordinary read samples the pins
				rd_val = get_byte(pin_level, rd_addr);
				if (rd_addr == PORT_ONE && p1_sel_active) begin
					if (st.portctl) begin
						rd_val = get_byte(st.latch, PORT_ONE);
					end else begin
						// Outputs give latch, inputs give pin level
						rd_val = (p1_dir & get_byte(st.latch, PORT_ONE))
							| (~p1_dir & get_byte(pin_level, PORT_ONE));
					end
				end
			end
			next_st.rd_data = rd_val;
		end
		next_st.rd_valid = rd_en;
		// Drive registered so every pin output comes from a flop; costs one cycle
		next_st.pin_out = pc.next_out;
		next_st.pin_oe = pc.next_oe;
		next_st.pin_pullup = pc.next_pu;
		next_st.readback_latch = p1_sel_active && st.portctl;
	end

	// Single state register; clock enable freezes everything
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			st <= STATE_RESET;
		end else if (ce) begin
			st <= next_st;
		end
	end

	assign rd_data = st.rd_data;
	assign rd_valid = st.rd_valid;
	assign pin_out = st.pin_out;
	assign pin_oe = st.pin_oe;
	assign pin_pullup = st.pin_pullup;
	assign readback_latch = st.readback_latch;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	sequence dir_wr_port0_s;
		ce && wr_en && wr_sel == SEL_DIR && wr_addr == 4'h0;
	endsequence

	sequence p1_latch_read_s;
		ce && rd_en && rd_addr == PORT_ONE && st.portctl && p1_sel_active;
	endsequence

	sequence p1_pin_read_s;
		ce && rd_en && rd_addr == PORT_ONE && !p1_sel_active;
	endsequence

	dir_oe_follow_a: assert property (ce |=> pin_oe == (($past(st.dir) | $past(periph_oe))
		& VALID_MASK)) else $error("pin enable does not follow direction");
	inonly_undriven_a: assert property (!pin_oe[IN_ONLY_SLOT] && !pin_pullup[IN_ONLY_SLOT]
		&& !st.dir[IN_ONLY_SLOT]) else $error("input-only pin driven or pulled");
	pu_group_on_a: assert property (ce && st.pug[1] && st.dir[7:4] == 4'h0 && !ext_mode
		|=> pin_pullup[7:4] == 4'hF) else $error("pull-up group not applied");
	pu_output_off_a: assert property (ce |=> (pin_pullup & $past(st.dir)) == '0)
		else $error("pull-up on output pin");
	periph_drive_a: assert property (ce |=> ((pin_out ^ $past(periph_out))
		& $past(periph_oe) & VALID_MASK) == '0) else $error("peripheral not driving");
	dir_map_a: assert property (dir_wr_port0_s |=> st.dir[7:0] == $past(wr_data))
		else $error("direction byte misplaced");
	latch_load_a: assert property (ce && wr_en && wr_sel == SEL_LATCH && wr_addr == 4'h2
		|=> st.latch[23:16] == $past(wr_data)) else $error("latch not loaded");
	bus_pu_off_a: assert property (ce && ext_mode |=> (pin_pullup & BUS_SLOT_MASK) == '0)
		else $error("bus port pull-up active");
	p1_latch_read_a: assert property (p1_latch_read_s |=> rd_valid
		&& rd_data == $past(st.latch[15:8])) else $error("port one latch read-back wrong");
	p1_plain_read_a: assert property (p1_pin_read_s |=> rd_data == $past(pin_in[15:8]))
		else $error("port one read-back switch active outside its modes");
	dir_reset_a: assert property (@(posedge clk_sys) disable iff (1'b0) !arst_n |-> st.dir == '0
		&& pin_oe == '0) else $error("direction not input during reset");
endmodule // programmable_io_port_bank
`default_nettype wire

// ===== logic/io_bank_pkg.sv
`default_nettype none
package io_bank_pkg;
	// Pin space: eleven eight-bit ports, one slot reserved for the input-only pin
	localparam int PORT_W = 8;
	localparam int NUM_PORTS = 11;
	localparam int SLOTS = 88;
	localparam int GROUP_W = 4;
	localparam int NUM_GROUPS = 22;
	localparam int GROUPS_PER_BYTE = 2;
	localparam int PU_BYTES = 3;
	localparam int IN_ONLY_SLOT = 69;
	localparam logic [3:0] PORT_ONE = 4'h1;
	localparam logic [3:0] PORT_LAST = 4'hA;
	localparam logic [1:0] PU_BYTE_LAST = 2'h2;
	localparam int READBACK_BIT = 0;

	typedef logic [SLOTS-1:0] slot_t;
	typedef logic [PORT_W-1:0] byte_t;
	typedef logic [NUM_GROUPS-1:0] group_t;

	// Slots that carry a direction bit (all but the input-only slot)
	localparam slot_t VALID_MASK = 88'hFFFFDFFFFFFFFFFFFFFFFF;
	// Slots used by the external bus: ports 0 to 3, low nibble of port 4, port 5
	localparam slot_t BUS_SLOT_MASK = 88'h0000000000FF0FFFFFFFFF;

	localparam slot_t DIR_RESET = 88'h0;
	localparam slot_t LATCH_RESET = 88'h0;
	localparam group_t PU_RESET = 22'h0;
	localparam logic PORTCTL_RESET = 1'b0;

	// Write target selector
	typedef enum logic [1:0] {
		SEL_DIR = 2'h0,
		SEL_LATCH = 2'h1,
		SEL_PULLUP = 2'h2,
		SEL_PORTCTL = 2'h3
	} wr_sel_e;
endpackage
`default_nettype wire

// ===== logic/pin_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface pin_ctl_if;
	import io_bank_pkg::*;
	slot_t dir;
	slot_t latch;
	group_t pug;
	logic ext_mode;
	slot_t periph_oe;
	slot_t periph_out;
	slot_t next_out;
	slot_t next_oe;
	slot_t next_pu;

	modport bank (output dir, latch, pug, ext_mode, periph_oe, periph_out,
		input next_out, next_oe, next_pu);
	modport calc (input dir, latch, pug, ext_mode, periph_oe, periph_out,
		output next_out, next_oe, next_pu);
endinterface
`default_nettype wire

// ===== logic/pin_drive_calc.sv
`timescale 1ns/1ps
`default_nettype none
module pin_drive_calc (
	pin_ctl_if.calc pc
);
	import io_bank_pkg::*;

	// Peripheral outputs take the pin regardless of direction
	// Peripheral inputs and D-A outputs rely on software leaving direction at input
	assign pc.next_oe = (pc.dir | pc.periph_oe) & VALID_MASK;
	assign pc.next_out = ((pc.periph_oe & pc.periph_out) | (~pc.periph_oe & pc.latch))
		& VALID_MASK;

	// Group enable spread over four pins, masked by direction and bus mode
	always_comb begin
		slot_t spread;
		slot_t bus_off;
		spread = '0;
		for (int i = 0; i < SLOTS; i++) begin
			spread[i] = pc.pug[i / GROUP_W];
		end
		// External bus pins ignore their pull-up controls in expansion modes
		bus_off = pc.ext_mode ? BUS_SLOT_MASK : '0;
		pc.next_pu = spread & ~pc.dir & ~bus_off & VALID_MASK;
	end
endmodule // pin_drive_calc
`default_nettype wire

// ===== dv/pin_world.sv
`timescale 1ns/1ps
`default_nettype none
module pin_world (
	input wire logic clk_sys,
	input wire io_bank_pkg::slot_t pin_out,
	input wire io_bank_pkg::slot_t pin_oe,
	input wire io_bank_pkg::slot_t pin_pullup,
	input wire io_bank_pkg::slot_t ext_oe,
	input wire io_bank_pkg::slot_t ext_val,
	output io_bank_pkg::slot_t pin_in
);
	import io_bank_pkg::*;
	slot_t flip = '0;
	// Undriven lines wander, so a stale level never passes for a driven one
	always @(posedge clk_sys) begin
		flip <= ~flip;
	end
	// Port driver beats the external resistors; then pull-up, else floating
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
		| (~pin_oe & ~ext_oe & pin_pullup)
		| (~pin_oe & ~ext_oe & ~pin_pullup & flip);
endmodule // pin_world
`default_nettype wire

// ===== dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import io_bank_pkg::*;
	logic clk_sys = 1'b0, arst_n = 1'b0, ce = 1'b1, wr_en = 1'b0, rd_en = 1'b0, act;
	logic ext_mode = 1'b0, bus_8bit = 1'b0, mux_full_space = 1'b0, input_only_pin = 1'b0;
	logic rd_valid, readback_latch;
	wr_sel_e wr_sel = SEL_DIR;
	logic [3:0] wr_addr = 4'h0, rd_addr = 4'h0;
	byte_t wr_data = 8'h00;
	logic [7:0] rd_data;
	slot_t periph_oe = '0, periph_out = '0, pin_in, pin_out, pin_oe, pin_pullup, exp;
	slot_t ext_val = {11{8'hA6}};
	int errors = 0, compares = 0;
	always #12.5 clk_sys = ~clk_sys;
	programmable_io_port_bank dut (.clk_sys(clk_sys), .arst_n(arst_n), .ce(ce),
		.wr_en(wr_en), .wr_sel(wr_sel), .wr_addr(wr_addr), .wr_data(wr_data),
		.rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid),
		.ext_mode(ext_mode), .bus_8bit(bus_8bit), .mux_full_space(mux_full_space),
		.periph_oe(periph_oe), .periph_out(periph_out), .pin_in(pin_in),
		.input_only_pin(input_only_pin), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pullup), .readback_latch(readback_latch));
	// External circuit always leans on every pin through resistors
	pin_world far (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe(pin_oe),
		.pin_pullup(pin_pullup), .ext_oe('1), .ext_val(ext_val), .pin_in(pin_in));
	// Verdict and end of run
	task automatic stop_test();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input slot_t got, input slot_t want);
		compares++;
		if (got !== want) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, want);
		end
	endtask
	// One write strobe, dropped a cycle later so calls never collide
	task automatic wr(input wr_sel_e s, input logic [3:0] a, input byte_t d);
		@(posedge clk_sys);
		wr_en <= 1'b1;
		wr_sel <= s;
		wr_addr <= a;
		wr_data <= d;
		@(posedge clk_sys);
		wr_en <= 1'b0;
	endtask
	// Pin outputs lag the state by one edge
	task automatic settle();
		repeat (2) @(posedge clk_sys);
		#1;
	endtask
	task automatic rd(input logic [3:0] a, input byte_t want);
		int n;
		@(posedge clk_sys);
		rd_en <= 1'b1;
		rd_addr <= a;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		n = 0;
		#1;
		while (rd_valid !== 1'b1) begin
			n++;
			if (n > 4) begin
				errors++;
				stop_test();
			end
			@(posedge clk_sys);
			#1;
		end
		chk(slot_t'(rd_data), slot_t'(want));
	endtask
	task automatic done(input string name);
		$display("test %s finished", name);
	endtask
	// Main sequence
	initial begin
		repeat (8) @(posedge clk_sys);
		arst_n <= 1'b1;
		#1;
		chk(pin_oe | pin_out | pin_pullup, '0);
		chk(slot_t'(readback_latch), '0);
		done("reset");
		wr(SEL_DIR, 4'h0, 8'h02);
		wr(SEL_PULLUP, 4'h0, 8'h03);
		wr(SEL_PULLUP, 4'h1, 8'h13);
		settle();
		exp = '0;
		exp[7:0] = 8'hFD;
		exp[39:32] = 8'hFF;
		exp[51:48] = 4'hF;
		chk(pin_pullup, exp);
		@(posedge clk_sys);
		ext_mode <= 1'b1;
		settle();
		exp[7:0] = 8'h00;
		exp[35:32] = 4'h0;
		chk(pin_pullup, exp);
		done("pullup");
		wr(SEL_DIR, 4'h2, 8'hA5);
		wr(SEL_LATCH, 4'h2, 8'h3C);
		settle();
		exp = '0;
		exp[7:0] = 8'h02;
		exp[23:16] = 8'hA5;
		chk(pin_oe, exp);
		rd(4'h2, 8'h26);
		// Peripheral takes an input-direction pin whose latch holds the opposite level
		@(posedge clk_sys);
		periph_oe[20] <= 1'b1;
		settle();
		chk(slot_t'(pin_oe[23:16]), slot_t'(8'hB5));
		chk(slot_t'(pin_out[23:16]), slot_t'(8'h2C));
		done("port two");
		wr(SEL_DIR, 4'h8, 8'hFF);
		wr(SEL_LATCH, 4'h8, 8'hFF);
		wr(SEL_PULLUP, 4'h2, 8'h02);
		settle();
		chk(slot_t'(pin_oe[71:64]), slot_t'(8'hDF));
		chk(slot_t'(pin_pullup[71:68]), '0);
		rd(4'h8, 8'hDF);
		done("input only");
		// Writes with the clock enable low or a bad port number must vanish
		@(posedge clk_sys);
		ce <= 1'b0;
		wr(SEL_DIR, 4'h3, 8'hFF);
		@(posedge clk_sys);
		ce <= 1'b1;
		wr(SEL_DIR, 4'hB, 8'hFF);
		settle();
		chk(slot_t'(pin_oe[31:24]), '0);
		chk(slot_t'(pin_oe[87:72]), '0);
		rd(4'hC, 8'h00);
		done("refused");
		wr(SEL_DIR, 4'h1, 8'h0F);
		wr(SEL_LATCH, 4'h1, 8'h55);
		// Peripheral pulls output pin 0 of port one low, so pin and latch differ there
		@(posedge clk_sys);
		periph_oe[8] <= 1'b1;
		// Every mix of bus mode, width, multiplexing and control bit
		for (int i = 0; i < 16; i++) begin
			@(posedge clk_sys);
			ext_mode <= i[0];
			bus_8bit <= i[1];
			mux_full_space <= i[2];
			wr(SEL_PORTCTL, 4'h0, {7'h00, i[3]});
			settle();
			act = ((i[0] & i[1]) | i[2]) & i[3];
			chk(slot_t'(readback_latch), slot_t'(act));
			rd(4'h1, act ? 8'h55 : (((i[0] & i[1]) | i[2]) ? 8'hA5 : 8'hA4));
		end
		done("port one");
		stop_test();
	end
endmodule // tb_top
`default_nettype wire
